/* File: logic/bst_pkg.sv */
// Shared constants and types of the boundary-scan test port
`default_nettype none
package bst_pkg;
	// ------------------------------------------------------------
	// Instruction register
	// ------------------------------------------------------------
	localparam int IR_LEN = 3;
	localparam logic [2:0] IR_EXTEST = 3'h0;
	localparam logic [2:0] IR_SAMPLE = 3'h5;
	localparam logic [2:0] IR_BYPASS = 3'h7;
	localparam logic [2:0] IR_CAPTURE = 3'h1;
	// ------------------------------------------------------------
	// Boundary register lengths per variant
	// ------------------------------------------------------------
	localparam int BSR_LEN_V0 = 273;
	localparam int BSR_LEN_V1 = 417;
	localparam int BSR_LEN_V2 = 465;
	localparam int BSR_LEN_V3 = 645;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic PULL_LEVEL = 1'h1;
	localparam logic BYPASS_CAPTURE = 1'h0;
	localparam int TLR_TMS_ONES = 5;
	// ------------------------------------------------------------
	// Controller states
	// ------------------------------------------------------------
	typedef enum logic [15:0] {
		TLR = 16'h0001,
		RTI = 16'h0002,
		SEL_DR = 16'h0004,
		CAP_DR = 16'h0008,
		SH_DR = 16'h0010,
		EX1_DR = 16'h0020,
		PAU_DR = 16'h0040,
		EX2_DR = 16'h0080,
		UPD_DR = 16'h0100,
		SEL_IR = 16'h0200,
		CAP_IR = 16'h0400,
		SH_IR = 16'h0800,
		EX1_IR = 16'h1000,
		PAU_IR = 16'h2000,
		EX2_IR = 16'h4000,
		UPD_IR = 16'h8000
	} bst_state_e;
endpackage
`default_nettype wire

/* File: logic/bst_tap.sv */
// Boundary-scan test port: controller, instruction, bypass and boundary registers
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Three-bit instruction register shifted in IR path
// - Bypass places one-bit register TDI to TDO
// - Bypass passes data, functional pins untouched
// - Sample captures pin states, operation continues
// - Preload shifts pattern into update cells
// - External test drives pins from cells
// - External test captures input pins
// - Length parameter 273 or 417 cells
// - Length parameter 465 or 645 cells
// - Undriven test inputs read as one
module bst_tap #(
	parameter int BSR_LEN = bst_pkg::BSR_LEN_V0
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic [BSR_LEN-1:0] pin_in,
	input wire logic [BSR_LEN-1:0] core_out,
	output logic [BSR_LEN-1:0] pin_out,
	output logic mon_valid,
	output logic mon_data,
	input wire logic mon_ready,
	output logic mon_room
);
	// ------------------------------------------------------------
	// Decoding
	// ------------------------------------------------------------
	function automatic logic sel_bypass(input logic [2:0] code);
		sel_bypass = (code != bst_pkg::IR_EXTEST) && (code != bst_pkg::IR_SAMPLE);
	endfunction
	function automatic logic is_known(input logic [2:0] code);
		is_known = (code == bst_pkg::IR_EXTEST) || (code == bst_pkg::IR_SAMPLE) ||
			(code == bst_pkg::IR_BYPASS);
	endfunction

	// ------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------
	// Reset to the pull level so a floating port reads as one
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic tck_d;
	logic [BSR_LEN-1:0] pin_s1;
	logic [BSR_LEN-1:0] pin_s2;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1 <= {3{bst_pkg::PULL_LEVEL}};
			sync2 <= {3{bst_pkg::PULL_LEVEL}};
			tck_d <= bst_pkg::PULL_LEVEL;
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			sync1 <= {tck, tms, tdi};
			sync2 <= sync1;
			tck_d <= sync2[2];
			pin_s1 <= pin_in;
			pin_s2 <= pin_s1;
		end
	end
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic rise;
	logic fall;
	assign tck_s = sync2[2];
	assign tms_s = sync2[1];
	assign tdi_s = sync2[0];
	assign rise = tck_s & ~tck_d;
	assign fall = ~tck_s & tck_d;

	// ------------------------------------------------------------
	// Controller and registers
	// ------------------------------------------------------------
	bst_pkg::bst_state_e state;
	bst_pkg::bst_state_e next_state;
	logic [2:0] ir;
	logic [2:0] next_ir;
	logic [2:0] ir_sh;
	logic [2:0] next_ir_sh;
	logic byp;
	logic next_byp;
	logic [BSR_LEN-1:0] bsr;
	logic [BSR_LEN-1:0] next_bsr;
	logic [BSR_LEN-1:0] upd;
	logic [BSR_LEN-1:0] next_upd;
	logic next_tdo;
	logic next_tdo_oe;
	logic [BSR_LEN-1:0] next_pin_out;
	logic shift_bit;

	// Bit leaving the selected path during a shift
	always_comb begin
		if (state == bst_pkg::SH_IR)
			shift_bit = ir_sh[0];
		else if (sel_bypass(ir))
			shift_bit = byp;
		else
			shift_bit = bsr[0];
	end

	always_comb begin
		next_state = state;
		if (rise) begin
			case (state)
				bst_pkg::TLR: next_state = tms_s ? bst_pkg::TLR : bst_pkg::RTI;
				bst_pkg::RTI: next_state = tms_s ? bst_pkg::SEL_DR : bst_pkg::RTI;
				bst_pkg::SEL_DR: next_state = tms_s ? bst_pkg::SEL_IR : bst_pkg::CAP_DR;
				bst_pkg::CAP_DR: next_state = tms_s ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
				bst_pkg::SH_DR: next_state = tms_s ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
				bst_pkg::EX1_DR: next_state = tms_s ? bst_pkg::UPD_DR : bst_pkg::PAU_DR;
				bst_pkg::PAU_DR: next_state = tms_s ? bst_pkg::EX2_DR : bst_pkg::PAU_DR;
				bst_pkg::EX2_DR: next_state = tms_s ? bst_pkg::UPD_DR : bst_pkg::SH_DR;
				bst_pkg::UPD_DR: next_state = tms_s ? bst_pkg::SEL_DR : bst_pkg::RTI;
				bst_pkg::SEL_IR: next_state = tms_s ? bst_pkg::TLR : bst_pkg::CAP_IR;
				bst_pkg::CAP_IR: next_state = tms_s ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
				bst_pkg::SH_IR: next_state = tms_s ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
				bst_pkg::EX1_IR: next_state = tms_s ? bst_pkg::UPD_IR : bst_pkg::PAU_IR;
				bst_pkg::PAU_IR: next_state = tms_s ? bst_pkg::EX2_IR : bst_pkg::PAU_IR;
				bst_pkg::EX2_IR: next_state = tms_s ? bst_pkg::UPD_IR : bst_pkg::SH_IR;
				bst_pkg::UPD_IR: next_state = tms_s ? bst_pkg::SEL_DR : bst_pkg::RTI;
				default: next_state = bst_pkg::TLR;
			endcase
		end
	end

	always_comb begin
		next_ir = ir;
		next_ir_sh = ir_sh;
		next_byp = byp;
		next_bsr = bsr;
		next_upd = upd;
		if (rise) begin
			case (state)
				bst_pkg::TLR: next_ir = bst_pkg::IR_BYPASS;
				bst_pkg::CAP_IR: next_ir_sh = bst_pkg::IR_CAPTURE;
				bst_pkg::SH_IR: next_ir_sh = {tdi_s, ir_sh[2:1]};
				bst_pkg::UPD_IR: next_ir = ir_sh;
				bst_pkg::CAP_DR: begin
					if (sel_bypass(ir))
						next_byp = bst_pkg::BYPASS_CAPTURE;
					else
						next_bsr = pin_s2;
				end
				bst_pkg::SH_DR: begin
					if (sel_bypass(ir))
						next_byp = tdi_s;
					else
						next_bsr = {tdi_s, bsr[BSR_LEN-1:1]};
				end
				bst_pkg::UPD_DR: begin
					if (!sel_bypass(ir))
						next_upd = bsr;
				end
				default: ;
			endcase
		end
	end

	// TDO changes on the falling edge so the tester samples a settled bit
	always_comb begin
		next_tdo = tdo;
		next_tdo_oe = tdo_oe;
		if (fall) begin
			next_tdo_oe = (state == bst_pkg::SH_DR) || (state == bst_pkg::SH_IR);
			next_tdo = next_tdo_oe ? shift_bit : 1'h0;
		end
		// Functional pins keep their core values unless external test runs
		next_pin_out = (ir == bst_pkg::IR_EXTEST) ? upd : core_out;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= bst_pkg::TLR;
			ir <= bst_pkg::IR_BYPASS;
			ir_sh <= bst_pkg::IR_CAPTURE;
			byp <= bst_pkg::BYPASS_CAPTURE;
			bsr <= '0;
			upd <= '0;
			tdo <= 1'h0;
			tdo_oe <= 1'h0;
			pin_out <= '0;
		end else begin
			state <= next_state;
			ir <= next_ir;
			ir_sh <= next_ir_sh;
			byp <= next_byp;
			bsr <= next_bsr;
			upd <= next_upd;
			tdo <= next_tdo;
			tdo_oe <= next_tdo_oe;
			pin_out <= next_pin_out;
		end
	end

	// ------------------------------------------------------------
	// Two-entry monitor buffer of shifted-out bits
	// ------------------------------------------------------------
	// The scan clock cannot be stalled; a bit offered while full is dropped
	logic tail_v;
	logic tail_d;
	logic next_head_v;
	logic next_head_d;
	logic next_tail_v;
	logic next_tail_d;
	logic push;
	logic pop;
	assign push = rise && mon_room && ((state == bst_pkg::SH_DR) || (state == bst_pkg::SH_IR));
	assign pop = mon_valid && mon_ready;
	always_comb begin
		next_head_v = mon_valid;
		next_head_d = mon_data;
		next_tail_v = tail_v;
		next_tail_d = tail_d;
		if (pop) begin
			next_head_v = tail_v | push;
			next_head_d = tail_v ? tail_d : shift_bit;
			next_tail_v = 1'h0;
		end else if (push) begin
			if (!mon_valid) begin
				next_head_v = 1'h1;
				next_head_d = shift_bit;
			end else begin
				next_tail_v = 1'h1;
				next_tail_d = shift_bit;
			end
		end
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mon_valid <= 1'h0;
			mon_data <= 1'h0;
			tail_v <= 1'h0;
			tail_d <= 1'h0;
			mon_room <= 1'h1;
		end else begin
			mon_valid <= next_head_v;
			mon_data <= next_head_d;
			tail_v <= next_tail_v;
			tail_d <= next_tail_d;
			mon_room <= ~next_tail_v;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	logic [2:0] ones_cnt;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			ones_cnt <= 3'h0;
		else if (rise)
			ones_cnt <= !tms_s ? 3'h0 :
				(ones_cnt == 3'(bst_pkg::TLR_TMS_ONES)) ? 3'(bst_pkg::TLR_TMS_ONES) :
				ones_cnt + 3'h1;
	end
	sequence s_rise_in(bst_pkg::bst_state_e st, logic cond);
		rise && state == st && cond;
	endsequence
	property p_ir_update;
		@(posedge ref_clk) disable iff (!reset_n)
		s_rise_in(bst_pkg::UPD_IR, 1'h1) |=> ir == $past(ir_sh);
	endproperty
	a_ir_update: assert property (p_ir_update) else $error("ir not loaded");
	property p_bypass_tdo;
		@(posedge ref_clk) disable iff (!reset_n)
		fall && state == bst_pkg::SH_DR && sel_bypass(ir) |=> tdo == $past(byp) && tdo_oe;
	endproperty
	a_bypass_tdo: assert property (p_bypass_tdo) else $error("bypass tdo wrong");
	property p_bypass_cap;
		@(posedge ref_clk) disable iff (!reset_n)
		s_rise_in(bst_pkg::CAP_DR, sel_bypass(ir)) |=> byp == 1'h0 && $stable(bsr);
	endproperty
	a_bypass_cap: assert property (p_bypass_cap) else $error("bypass capture wrong");
	property p_sample;
		@(posedge ref_clk) disable iff (!reset_n)
		s_rise_in(bst_pkg::CAP_DR, !sel_bypass(ir)) |=> bsr == $past(pin_s2);
	endproperty
	a_sample: assert property (p_sample) else $error("pins not captured");
	property p_preload;
		@(posedge ref_clk) disable iff (!reset_n)
		s_rise_in(bst_pkg::UPD_DR, !sel_bypass(ir)) |=> upd == $past(bsr);
	endproperty
	a_preload: assert property (p_preload) else $error("update cells not loaded");
	property p_extest;
		@(posedge ref_clk) disable iff (!reset_n)
		ir == bst_pkg::IR_EXTEST |=> pin_out == $past(upd);
	endproperty
	a_extest: assert property (p_extest) else $error("pins not from cells");
	property p_normal;
		@(posedge ref_clk) disable iff (!reset_n)
		// The edge that releases reset still loads the reset value into pin_out
		reset_n && ir != bst_pkg::IR_EXTEST |=> pin_out == $past(core_out);
	endproperty
	a_normal: assert property (p_normal) else $error("functional pins disturbed");
	property p_tlr;
		@(posedge ref_clk) disable iff (!reset_n)
		ones_cnt == 3'(bst_pkg::TLR_TMS_ONES) |-> state == bst_pkg::TLR;
	endproperty
	a_tlr: assert property (p_tlr) else $error("five tms ones not in reset");
	property p_unknown;
		@(posedge ref_clk) disable iff (!reset_n)
		s_rise_in(bst_pkg::SH_DR, !is_known(ir)) |=> byp == $past(tdi_s) && $stable(bsr);
	endproperty
	a_unknown: assert property (p_unknown) else $error("unknown code not bypass");
endmodule
`default_nettype wire

/* File: sim/bst_tester.sv */
// Board tester model that drives the four-wire scan port
`timescale 1ns/1ps
`default_nettype none
module bst_tester #(
	parameter int W = 273
) (
	input wire logic ref_clk,
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	// Idle lines rest at the pull-up level
	initial begin
		tck = 1'h1;
		tms = 1'h1;
		tdi = 1'h1;
	end
	// ------------------------------------------------------------
	// One scan clock of eight ref_clk periods, tdo taken at the rise
	// ------------------------------------------------------------
	task automatic step(input logic m, input logic d, output logic o);
		@(posedge ref_clk);
		tck <= 1'h0;
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge ref_clk);
		o = tdo;
		tck <= 1'h1;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic to_idle();
		logic o;
		repeat (5) step(1'h1, tdi, o);
		step(1'h0, tdi, o);
	endtask
	// From idle through one capture, shift and update, back to idle
	task automatic scan(input bit ir, input int n, input logic [W-1:0] din,
		output logic [W-1:0] dout);
		logic o;
		dout = '0;
		step(1'h1, tdi, o);
		if (ir) begin
			step(1'h1, tdi, o);
		end
		step(1'h0, tdi, o);
		step(1'h0, tdi, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'h1, tdi, o);
		step(1'h0, tdi, o);
		// Stale data is not left on the line between frames
		tdi <= ~tdi;
	endtask
endmodule
`default_nettype wire

/* File: sim/test_boundary_scan_test_port.sv */
// Self-checking bench of the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module test_boundary_scan_test_port;
	localparam int N = bst_pkg::BSR_LEN_V0;
	localparam logic [N-1:0] PA = {91{3'h5}};
	localparam logic [N-1:0] PB = {91{3'h3}};
	localparam logic [N-1:0] PC = {91{3'h6}};
	localparam logic [N-1:0] PD = {91{3'h1}};
	logic ref_clk, reset_n, tck, tms, tdi, tdo, tdo_oe;
	logic [N-1:0] pin_in, core_out, pin_out;
	logic mon_valid, mon_data, mon_ready, mon_room;
	int bad_count, checks, cycles;
	// Second device of the largest variant on its own scan port
	localparam int W3 = bst_pkg::BSR_LEN_V3;
	logic w_tck, w_tms, w_tdi, w_tdo, w_mon_ready;
	logic [W3-1:0] w_pin_in, w_core_out, w_pin_out;
	bst_tap #(.BSR_LEN(N)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .tck(tck),
		.tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in),
		.core_out(core_out), .pin_out(pin_out), .mon_valid(mon_valid),
		.mon_data(mon_data), .mon_ready(mon_ready), .mon_room(mon_room));
	bst_tester #(.W(N)) tst (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo));
	bst_tap #(.BSR_LEN(W3)) dut_wide (.ref_clk(ref_clk), .reset_n(reset_n), .tck(w_tck),
		.tms(w_tms), .tdi(w_tdi), .tdo(w_tdo), .tdo_oe(), .pin_in(w_pin_in),
		.core_out(w_core_out), .pin_out(w_pin_out), .mon_valid(),
		.mon_data(), .mon_ready(w_mon_ready), .mon_room());
	bst_tester #(.W(W3)) tst_wide (.ref_clk(ref_clk), .tck(w_tck), .tms(w_tms),
		.tdi(w_tdi), .tdo(w_tdo));
	always #25 ref_clk = ~ref_clk;
	// ------------------------------------------------------------
	// Reporting
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [N-1:0] seen,
		input logic [N-1:0] exp);
		checks++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, seen);
			bad_count++;
		end
	endtask
	task automatic complete_run();
		$display("mismatches %0d, checks %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// A scan run takes under 12000 cycles; this cuts a hang short
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			complete_run();
		end
	end
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic load_ir(input logic [2:0] code);
		logic [N-1:0] d;
		tst.scan(1'b1, 3, N'(code), d);
		check("ir capture", d, N'(3'h1));
	endtask
	task automatic t_reset();
		repeat (3) @(posedge ref_clk);
		check("tdo_oe idle", N'(tdo_oe), N'(1'h0));
		check("mon_room idle", N'(mon_room), N'(1'h1));
		check("pin_out normal", pin_out, core_out);
	endtask
	// Snapshot of the pins while the core keeps driving them
	task automatic t_sample();
		logic [N-1:0] d;
		core_out <= PA;
		pin_in <= PB;
		load_ir(bst_pkg::IR_SAMPLE);
		tst.scan(1'b0, N, PC, d);
		check("sample capture", d, PB);
		check("pin_out in sample", pin_out, PA);
	endtask
	task automatic t_extest();
		logic [N-1:0] d;
		load_ir(bst_pkg::IR_EXTEST);
		repeat (2) @(posedge ref_clk);
		check("preloaded pins", pin_out, PC);
		pin_in <= PD;
		tst.scan(1'b0, N, PA ^ PB, d);
		check("extest capture", d, PD);
		repeat (2) @(posedge ref_clk);
		check("extest drive", pin_out, PA ^ PB);
	endtask
	// Eight bits through the one-bit path with the monitor stalled
	task automatic t_bypass(input logic [2:0] code);
		logic [N-1:0] d;
		load_ir(code);
		core_out <= PB;
		mon_ready <= 1'h0;
		tst.scan(1'b0, 8, N'(8'ha5), d);
		check("bypass path", d, N'(8'h4a));
		check("pin_out in bypass", pin_out, PB);
		check("monitor full", N'(mon_room), N'(1'h0));
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			check("monitor bit", N'(mon_data), N'(d[i]));
			mon_ready <= 1'h1;
			@(posedge ref_clk);
			mon_ready <= 1'h0;
		end
		repeat (2) @(posedge ref_clk);
		check("monitor empty", N'(mon_valid), N'(1'h0));
		mon_ready <= 1'h1;
	endtask
	// Largest variant: the lowest and highest 273 snapshot bits return and no tdi bit leaks in early
	task automatic t_wide();
		logic [W3-1:0] d;
		w_pin_in <= {215{3'h5}};
		tst_wide.to_idle();
		tst_wide.scan(1'b1, 3, W3'(bst_pkg::IR_SAMPLE), d);
		check("wide ir capture", d[N-1:0], N'(3'h1));
		tst_wide.scan(1'b0, W3, '0, d);
		check("wide capture low", d[N-1:0], PA);
		check("wide capture high", d[W3-1-:N], PA);
		check("wide pin_out", w_pin_out[N-1:0], PB);
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'h0;
		reset_n = 1'h0;
		pin_in = '0;
		core_out = PD;
		mon_ready = 1'h1;
		w_pin_in = '0;
		w_core_out = {215{3'h3}};
		w_mon_ready = 1'h1;
		bad_count = 0;
		checks = 0;
		cycles = 0;
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'h1;
		t_reset();
		repeat (4) @(posedge ref_clk);
		tst.to_idle();
		t_sample();
		t_extest();
		t_bypass(bst_pkg::IR_BYPASS);
		t_bypass(3'h3);
		t_bypass(3'h6);
		t_wide();
		complete_run();
	end
endmodule
`default_nettype wire
